// ==== src/ee_dev.sv ====
// Purpose: slave end of the two-wire eeprom link, write path plus simple read
// Assumes: scl and sda come from another domain; memory port outside
// Notes: programmed bytes leave through a small fifo as address/data words
//
// Operation
// - sda fall with scl high starts slave
// - stop during read returns to standby
// - stop during write launches internal write
// - sda change with scl high is start/stop
// - receiver pulls sda low on ninth clock
// - no acknowledge while internal write runs
// - seven address bits plus direction follow start
// - upper four address bits must be 1010
// - both select bits must be zero
// - match acks and picks direction, else standby
// - master uses random read after other slave
// - byte write: address, word, data, stop
// - busy device ignores bus, takes no commands
// - more data bytes: page mode, sixteen bytes
// - only four low word bits increment
// - page address wraps, last byte wins
// - stop programs all page bytes from base
// - master polls: nack busy, ack done
// - sda only pulled low, else released
// - act on both scl edges
// - direction one reads, msb first
`timescale 1ns/1ps
`default_nettype none
`include "ee_params.svh"

// ----------------------------------------
// fifo
// ----------------------------------------
module ee_fifo #(
  parameter int W = `EE_FIFO_W,
  parameter int D = `EE_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  // depth must be a power of two, pointers wrap freely
  assign in_ready = cnt_r != (AW+1)'(D);
  assign out_valid = cnt_r != '0;
  assign out_data = mem[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + AW'(1);
      end
      if (pop) begin
        rp_r <= rp_r + AW'(1);
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // ee_fifo

// ----------------------------------------
// slave end
// ----------------------------------------
module ee_dev #(
  parameter int WC_CYCLES = `EE_WC_CYC
) (
  input wire logic clk,
  input wire logic rst,
  ee_if.dev bus,
  output logic mem_valid,
  input wire logic mem_ready,
  output logic [8:0] mem_addr,
  output logic [7:0] mem_data,
  output logic [8:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic busy
);
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  ee_pkg::ee_dev_st_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic mack_r;
  logic oe_r;
  logic [8:0] addr_r;
  logic [7:0] base_r;
  logic [7:0] pg_mem [`EE_PAGE_BYTES];
  logic [`EE_PAGE_BYTES-1:0] pg_vld_r;
  logic pg_wr;
  logic go_r;
  logic busy_r;
  logic fl_act_r;
  logic [3:0] fl_k_r;
  logic [3:0] fl_idx;
  logic [21:0] tmr_r;
  logic fl_valid;
  logic fl_ready;
  logic [16:0] fifo_out;

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.sda};
    end
  end

  // edges from the second and third stages only
  assign scl_rise = scl_q[1] & ~scl_q[2];
  assign scl_fall = ~scl_q[1] & scl_q[2];
  assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
  assign stop = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
  assign pg_wr = scl_fall && bit_cnt_r == `EE_ACK_BIT && state_r == ee_pkg::EE_ST_DATA;

  // ----------------------------------------
  // protocol
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ee_pkg::EE_ST_IDLE;
      bit_cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      mack_r <= 1'b0;
      oe_r <= 1'b0;
      addr_r <= 9'h000;
      base_r <= 8'h00;
      pg_vld_r <= '0;
      go_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      if (start) begin
        state_r <= ee_pkg::EE_ST_ADDR;
        bit_cnt_r <= 4'h0;
        oe_r <= 1'b0;
      end else if (stop) begin
        state_r <= ee_pkg::EE_ST_IDLE;
        bit_cnt_r <= 4'h0;
        oe_r <= 1'b0;
        if (state_r == ee_pkg::EE_ST_DATA && pg_vld_r != '0) begin
          go_r <= 1'b1;
        end
      end else if (state_r != ee_pkg::EE_ST_IDLE) begin
        if (scl_rise) begin
          if (bit_cnt_r < `EE_ACK_BIT) begin
            sh_r <= {sh_r[6:0], sda_q[1]};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (bit_cnt_r == `EE_ACK_BIT) begin
            mack_r <= sda_q[1];
            bit_cnt_r <= `EE_END_BIT;
          end
        end else if (scl_fall) begin
          if (bit_cnt_r == `EE_ACK_BIT) begin
            unique case (state_r)
              ee_pkg::EE_ST_ADDR: begin
                // busy looks like a mismatch, so polling sees no ack
                if (sh_r[7:4] == `EE_DEV_CODE && sh_r[3:2] == `EE_SEL_CODE && !busy_r) begin
                  oe_r <= 1'b1;
                  addr_r[8] <= sh_r[1];
                  state_r <= sh_r[0] ? ee_pkg::EE_ST_TX : ee_pkg::EE_ST_WORD;
                end else begin
                  state_r <= ee_pkg::EE_ST_IDLE;
                end
              end
              ee_pkg::EE_ST_WORD: begin
                oe_r <= 1'b1;
                addr_r[7:0] <= sh_r;
                base_r <= sh_r;
                pg_vld_r <= '0;
                state_r <= ee_pkg::EE_ST_DATA;
              end
              ee_pkg::EE_ST_DATA: begin
                oe_r <= 1'b1;
                pg_vld_r[addr_r[3:0]] <= 1'b1;
                addr_r[3:0] <= addr_r[3:0] + 4'h1;
              end
              ee_pkg::EE_ST_TX: begin
                oe_r <= 1'b0; // master acknowledges
              end
              ee_pkg::EE_ST_IDLE, ee_pkg::EE_ST_WAIT: begin
              end
            endcase
          end else if (bit_cnt_r == `EE_END_BIT) begin
            oe_r <= 1'b0;
            bit_cnt_r <= 4'h0;
            if (state_r == ee_pkg::EE_ST_TX) begin
              if (!mack_r) begin
                tx_r <= {rd_data[6:0], 1'b0};
                oe_r <= ~rd_data[7];
                addr_r <= addr_r + 9'h001;
              end else begin
                state_r <= ee_pkg::EE_ST_WAIT;
              end
            end
          end else if (state_r == ee_pkg::EE_ST_TX && bit_cnt_r != 4'h0) begin
            oe_r <= ~tx_r[7];
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
      end
    end
  end

  // a rewritten offset simply overwrites, so the last byte wins
  always_ff @(posedge clk) begin
    if (pg_wr) begin
      pg_mem[addr_r[3:0]] <= sh_r;
    end
  end

  // ----------------------------------------
  // internal write
  // ----------------------------------------
  assign fl_idx = base_r[3:0] + fl_k_r;
  assign fl_valid = fl_act_r & pg_vld_r[fl_idx];

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      fl_act_r <= 1'b0;
      fl_k_r <= 4'h0;
      tmr_r <= 22'h000000;
    end else if (go_r) begin
      busy_r <= 1'b1;
      fl_act_r <= 1'b1;
      fl_k_r <= 4'h0;
      tmr_r <= 22'(WC_CYCLES - 1);
    end else begin
      // stalled memory side keeps the device busy once the fifo fills and the flush waits
      if (fl_act_r && (fl_ready || !pg_vld_r[fl_idx])) begin
        fl_k_r <= fl_k_r + 4'h1;
        if (fl_k_r == 4'hf) begin
          fl_act_r <= 1'b0;
        end
      end
      if (tmr_r != 22'h000000) begin
        tmr_r <= tmr_r - 22'h000001;
      end else if (!fl_act_r) begin
        busy_r <= 1'b0;
      end
    end
  end

  ee_fifo #(
    .W(`EE_FIFO_W),
    .D(`EE_FIFO_DEPTH)
  ) ee_fifo_i (
    .clk(clk),
    .rst(rst),
    .in_valid(fl_valid),
    .in_ready(fl_ready),
    .in_data({addr_r[8], base_r[7:4], fl_idx, pg_mem[fl_idx]}),
    .out_valid(mem_valid),
    .out_ready(mem_ready),
    .out_data(fifo_out)
  );

  assign mem_addr = fifo_out[16:8];
  assign mem_data = fifo_out[7:0];
  assign rd_addr = addr_r;
  assign busy = busy_r;
  assign bus.dev_sda_oe = oe_r;
endmodule // ee_dev
`default_nettype wire

// ==== src/ee_params.svh ====
// Purpose: shared constants of the two-wire eeprom write slave and its master
// Assumes: clk at 250 MHz
// Notes: counts in clk cycles unless named otherwise
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH
// ----------------------------------------
// addressing
// ----------------------------------------
`define EE_DEV_CODE 4'ha
`define EE_SEL_CODE 2'h0
`define EE_PAGE_BYTES 16
`define EE_ACK_BIT 4'h8
`define EE_END_BIT 4'h9
// ----------------------------------------
// buffering
// ----------------------------------------
`define EE_FIFO_DEPTH 4
`define EE_FIFO_W 17
// ----------------------------------------
// timing
// ----------------------------------------
`define EE_CLK_KHZ 250000
`define EE_T_WC_MS 10
`define EE_WC_CYC (`EE_T_WC_MS * `EE_CLK_KHZ)
`define EE_QTR_CYC 8
`endif

// ==== src/ee_pkg.sv ====
// Purpose: types of the two-wire eeprom write slave and its master
// Assumes: nothing
// Notes: constants live in ee_params.svh
package ee_pkg;
  typedef enum logic [2:0] {EE_ST_IDLE, EE_ST_ADDR, EE_ST_WORD, EE_ST_DATA, EE_ST_TX,
                            EE_ST_WAIT} ee_dev_st_t;
  typedef enum logic [1:0] {EE_H_IDLE, EE_H_START, EE_H_BIT, EE_H_STOP} ee_host_st_t;
  typedef enum logic [1:0] {EE_OP_START, EE_OP_STOP, EE_OP_WRITE, EE_OP_READ} ee_op_t;
endpackage

// ==== src/ee_if.sv ====
// Purpose: two-wire link between master and eeprom slave
// Assumes: pull-up on the data line
// Notes: enables high pull the data line low
`timescale 1ns/1ps
`default_nettype none
interface ee_if;
  logic scl;
  logic host_sda_oe;
  logic dev_sda_oe;
  wire sda;
  // wired-and with a pull-up
  assign sda = ~(host_sda_oe | dev_sda_oe);
  modport host (output scl, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_oe);
endinterface
`default_nettype wire

// ==== src/ee_host.sv ====
// Purpose: master end of the two-wire eeprom link, byte-level commands
// Assumes: no clock stretching; scl made here by a divider
// Notes: one command at a time: start, stop, write byte, read byte
`timescale 1ns/1ps
`default_nettype none
`include "ee_params.svh"

module ee_host (
  input wire logic clk,
  input wire logic rst,
  ee_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire ee_pkg::ee_op_t cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  logic [1:0] sda_q;
  logic [7:0] qc_r;
  logic tick;
  ee_pkg::ee_host_st_t st_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] hs_r;
  logic [8:0] rx_r;
  logic scl_r;
  logic oe_r;

  // ----------------------------------------
  // sampling and divider
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_q <= 2'h3;
    end else begin
      sda_q <= {sda_q[0], bus.sda};
    end
  end

  // free running quarter-period enable
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      qc_r <= 8'h00;
    end else begin
      qc_r <= qc_r + 8'h01;
    end
  end
  assign tick = qc_r == 8'(`EE_QTR_CYC - 1);
  assign cmd_ready = st_r == ee_pkg::EE_H_IDLE;

  // ----------------------------------------
  // bus sequencer
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ee_pkg::EE_H_IDLE;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      hs_r <= 9'h000;
      rx_r <= 9'h000;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (st_r)
        ee_pkg::EE_H_IDLE: begin
          if (cmd_valid) begin
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            unique case (cmd_op)
              ee_pkg::EE_OP_START: st_r <= ee_pkg::EE_H_START;
              ee_pkg::EE_OP_STOP: st_r <= ee_pkg::EE_H_STOP;
              ee_pkg::EE_OP_WRITE: begin
                hs_r <= {cmd_data, 1'b1};
                st_r <= ee_pkg::EE_H_BIT;
              end
              ee_pkg::EE_OP_READ: begin
                hs_r <= {8'hff, cmd_last};
                st_r <= ee_pkg::EE_H_BIT;
              end
            endcase
          end
        end
        ee_pkg::EE_H_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            unique case (ph_r)
              2'h0: begin
                scl_r <= 1'b0;
                oe_r <= 1'b0;
              end
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b1;
              2'h3: begin
                scl_r <= 1'b0;
                st_r <= ee_pkg::EE_H_IDLE;
              end
            endcase
          end
        end
        ee_pkg::EE_H_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            unique case (ph_r)
              2'h0: begin
                scl_r <= 1'b0;
                oe_r <= 1'b1;
              end
              2'h1: scl_r <= 1'b1;
              2'h2: oe_r <= 1'b0;
              2'h3: st_r <= ee_pkg::EE_H_IDLE;
            endcase
          end
        end
        ee_pkg::EE_H_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            unique case (ph_r)
              2'h0: oe_r <= ~hs_r[8];
              2'h1: scl_r <= 1'b1;
              2'h2: rx_r <= {rx_r[7:0], sda_q[1]};
              2'h3: begin
                scl_r <= 1'b0;
                hs_r <= {hs_r[7:0], 1'b0};
                if (bit_r == `EE_ACK_BIT) begin
                  st_r <= ee_pkg::EE_H_IDLE;
                  rsp_valid <= 1'b1;
                  rsp_data <= rx_r[8:1];
                  rsp_ack <= ~rx_r[0];
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  assign bus.scl = scl_r;
  assign bus.host_sda_oe = oe_r;
endmodule // ee_host
`default_nettype wire

// ==== tb/ee_asserts.sv ====
// Purpose: link checks between the two-wire master and the eeprom slave
// Assumes: single clk domain; scl and sda sampled raw on clk
// Notes: bit counter restarts on every start; read frames known by their direction bit
`timescale 1ns/1ps
`default_nettype none
module ee_asserts #(
  parameter int WC_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda,
  input wire logic busy
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bitn_r;
  int bcnt_r;
  logic adr_r;
  logic rd_r;
  logic own_ack;
  always_ff @(posedge clk) begin
    scl_q_r <= rst ? 1'b1 : scl;
    sda_q_r <= rst ? 1'b1 : sda;
  end
  // counts scl rises inside a frame, ninth rise wraps
  always_ff @(posedge clk) begin
    if (rst || (scl && scl_q_r && sda_q_r && !sda)) begin
      bitn_r <= 4'h0;
    end else if (scl && !scl_q_r) begin
      bitn_r <= (bitn_r == 4'h8) ? 4'h0 : bitn_r + 4'h1;
    end
  end
  // direction is the eighth bit of the first byte after a start
  always_ff @(posedge clk) begin
    if (rst || (scl && scl_q_r && sda_q_r && !sda)) begin
      adr_r <= 1'b1;
      rd_r <= 1'b0;
    end else if (scl && !scl_q_r) begin
      if (adr_r && bitn_r == 4'h7) begin
        rd_r <= sda;
      end
      if (bitn_r == 4'h8) begin
        adr_r <= 1'b0;
      end
    end
  end
  // read data bytes are driven by the slave, so only its acks are checked there
  assign own_ack = adr_r | ~rd_r;
  always_ff @(posedge clk) begin
    bcnt_r <= (rst || !busy) ? 0 : bcnt_r + 1;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_dev_pulls_low: assert property (dev_sda_oe && !rd_r |-> bitn_r == 4'h8 || bitn_r == 4'h0)
    else $error("slave pulled sda outside an acknowledge");
  a_ack_ninth_bit: assert property ($rose(dev_sda_oe) && own_ack |-> bitn_r == 4'h8)
    else $error("slave pulled sda outside the ninth bit");
  a_ack_on_low: assert property ($rose(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("slave drive began with scl high");
  a_release_on_low: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("slave released sda with scl high");
  a_ack_held_high: assert property ($rose(scl) && dev_sda_oe |=> dev_sda_oe [*4])
    else $error("slave drive moved while scl high");
  a_busy_no_ack: assert property (busy |-> !$rose(dev_sda_oe))
    else $error("acknowledge during internal write");
  a_busy_hold: assert property ($rose(busy) |-> busy [*8])
    else $error("internal write ended at once");
  a_busy_min_len: assert property ($fell(busy) |-> bcnt_r >= WC_CYCLES - 2)
    else $error("internal write shorter than its cycle count");
  a_host_frees_ack: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("master drove sda during a slave drive");
  c_ack: cover property ($rose(dev_sda_oe));
  c_busy: cover property ($rose(busy));
  c_poll_busy: cover property (busy && $rose(scl) && bitn_r == 4'h8);
  c_read_nack: cover property (rd_r && !adr_r && $rose(scl) && bitn_r == 4'h8 && sda);
endmodule // ee_asserts
`default_nettype wire

// ==== tb/two_wire_eeprom_slave_write_test.sv ====
// Purpose: self-checking bench, master and slave joined over the link
// Assumes: host makes scl; memory port stalls at random
// Notes: short internal write count keeps the run small
`timescale 1ns/1ps
`default_nettype none
module two_wire_eeprom_slave_write_test;
  localparam int WC = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  ee_pkg::ee_op_t cmd_op = ee_pkg::EE_OP_START;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_last = 1'b0;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_ack;
  logic mem_valid;
  logic mem_ready = 1'b0;
  logic [8:0] mem_addr;
  logic [7:0] mem_data;
  logic [7:0] rd_data = 8'h00;
  logic [8:0] rd_addr;
  logic rd_hold = 1'b0;
  logic busy;
  logic stall = 1'b0;
  logic [8:0] rsp_q[$];
  logic [16:0] mem_q[$];
  logic [7:0] pg[$];
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  ee_if ee_if_i ();
  ee_dev #(.WC_CYCLES(WC)) ee_dev_i (.clk(clk), .rst(rst), .bus(ee_if_i.dev),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_addr(mem_addr), .mem_data(mem_data),
    .rd_addr(rd_addr), .rd_data(rd_data), .busy(busy));
  ee_host ee_host_i (.clk(clk), .rst(rst), .bus(ee_if_i.host), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_last(cmd_last),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  ee_asserts #(.WC_CYCLES(WC)) ee_asserts_i (.clk(clk), .rst(rst), .scl(ee_if_i.scl),
    .host_sda_oe(ee_if_i.host_sda_oe), .dev_sda_oe(ee_if_i.dev_sda_oe), .sda(ee_if_i.sda),
    .busy(busy));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %0s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic send(input ee_pkg::ee_op_t op, input logic [7:0] d, input logic ack);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    if (op == ee_pkg::EE_OP_WRITE || op == ee_pkg::EE_OP_READ) rsp_q.push_back({ack, d});
    do @(posedge clk); while (cmd_ready !== 1'b1);
    cmd_valid <= 1'b0;
  endtask
  // start, address, bytes, optional stop
  task automatic frame(input logic [7:0] a, input logic aa, input logic [7:0] b[$],
                       input logic ba, input logic stop);
    send(ee_pkg::EE_OP_START, 8'h00, 1'b0);
    send(ee_pkg::EE_OP_WRITE, a, aa);
    foreach (b[i]) send(ee_pkg::EE_OP_WRITE, b[i], ba);
    if (stop) send(ee_pkg::EE_OP_STOP, 8'h00, 1'b0);
  endtask
  // stop reaches the slave a few clk after it is taken
  task automatic settle(input logic exp_busy);
    do @(posedge clk); while (cmd_ready !== 1'b1);
    repeat (8) @(posedge clk);
    chk("busy", {16'h0, busy}, {16'h0, exp_busy});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 20000 && busy !== 1'b0; i++) @(posedge clk);
    chk("busy idle", {16'h0, busy}, 17'h0);
  endtask
  // ----------------------------------------
  // watchers and stimulus
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors++;
      wrap_up();
    end
  end
  always @(posedge clk) begin
    if (!rd_hold) rd_data <= 8'($urandom);
    mem_ready <= stall ? 1'b0 : 1'($urandom);
  end
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (rsp_q.size() == 0) chk("rsp extra", 17'h1, 17'h0);
      else chk("rsp", {8'h00, rsp_ack, rsp_data}, {8'h00, rsp_q.pop_front()});
    end
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      if (mem_q.size() == 0) chk("mem extra", 17'h1, 17'h0);
      else chk("mem", {mem_addr, mem_data}, mem_q.pop_front());
    end
  end
  initial begin
    logic [7:0] d;
    logic [7:0] bad[4];
    logic [3:0] off;
    bad = '{8'hb0, 8'ha4, 8'ha8, 8'h20};
    void'($urandom(32'hcb44));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    // byte write, then polls while busy and after
    d = 8'($urandom);
    mem_q.push_back({9'h035, d});
    frame(8'ha0, 1'b1, '{8'h35, d}, 1'b1, 1'b1);
    frame(8'ha0, 1'b0, '{}, 1'b0, 1'b1);
    wait_idle();
    frame(8'ha0, 1'b1, '{}, 1'b0, 1'b1);
    settle(1'b0);
    $display("test byte_write done");
    // wrong device code or select bits: no ack, bytes ignored
    foreach (bad[i]) begin
      frame(bad[i], 1'b0, '{8'h55}, 1'b0, 1'b1);
      settle(1'b0);
    end
    $display("test mismatch done");
    // page of 18 bytes from offset 14 with block bit set: wraps, last wins
    pg.delete();
    for (int i = 0; i < 18; i++) pg.push_back(8'($urandom));
    for (int k = 0; k < 16; k++) begin
      off = 4'(14 + k);
      mem_q.push_back({5'h11, off, pg[(k < 2) ? k + 16 : k]});
    end
    stall <= 1'b1;
    frame(8'ha2, 1'b1, '{8'h1e}, 1'b1, 1'b0);
    foreach (pg[i]) send(ee_pkg::EE_OP_WRITE, pg[i], 1'b1);
    send(ee_pkg::EE_OP_STOP, 8'h00, 1'b0);
    settle(1'b1);
    repeat (300) @(posedge clk);
    chk("mem_valid", {16'h0, mem_valid}, 17'h1);
    stall <= 1'b0;
    wait_idle();
    $display("test page_write done");
    // repeated start drops the open page, empty data stop writes nothing
    frame(8'ha0, 1'b1, '{8'h40, 8'h99}, 1'b1, 1'b0);
    frame(8'ha0, 1'b1, '{8'h41}, 1'b1, 1'b1);
    settle(1'b0);
    repeat (20) @(posedge clk);
    $display("test restart done");
    // one read byte with nack, then stop abandons the read
    chk("rd_addr", {8'h00, rd_addr}, 17'h041);
    rd_hold <= 1'b1;
    @(posedge clk);
    frame(8'ha1, 1'b1, '{}, 1'b0, 1'b0);
    cmd_last <= 1'b1;
    send(ee_pkg::EE_OP_READ, rd_data, 1'b0);
    send(ee_pkg::EE_OP_STOP, 8'h00, 1'b0);
    settle(1'b0);
    chk("rd_addr", {8'h00, rd_addr}, 17'h042);
    $display("test read done");
    chk("rsp left", 17'(rsp_q.size()), 17'h0);
    chk("mem left", 17'(mem_q.size()), 17'h0);
    wrap_up();
  end
endmodule // two_wire_eeprom_slave_write_test
`default_nettype wire
